// File: sfe_array_model.sv
// Array model answering each start after a short busy time
`timescale 1ns/100ps
module sfe_array_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic arr_start,
  input wire logic fail_req,
  output logic arr_done,
  output logic arr_fail
);
  logic [2:0] cnt; // Busy countdown
  logic tog; // Filler while no answer is due
  // Countdown from start, filler toggles every cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt <= '0;
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      if (arr_start) cnt <= 3'h3;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
  end
  assign arr_done = (cnt == 3'h1);
  assign arr_fail = arr_done ? fail_req : tog;
endmodule : sfe_array_model

// File: sfe_ctrl.sv
// Command checker and sequencer for the serial flash program, erase and protection logic
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "sfe_regs.svh"
module sfe_ctrl #(
  parameter int ADDR_W = 25
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire sfe_pkg::sfe_wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  input wire logic hw_reset_n,
  output sfe_pkg::sfe_arr_cmd_t arr_cmd,
  output logic arr_start,
  output logic arr_abort,
  input wire logic arr_done,
  input wire logic arr_fail,
  output sfe_pkg::sfe_link_t link_cfg,
  output logic irq
);
  import sfe_pkg::*;

  // Array size must cover the short address and fit the bank register
  if (ADDR_W < 25 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 25 and 32");
  end

  // Sequencer states
  typedef enum logic {SFE_IDLE, SFE_WAIT} sfe_fsm_t;

  // Whole state of the block
  typedef struct packed {
    sfe_fsm_t fsm;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] addr;
    logic [7:0] data;
    logic [7:0] cfg;
    logic [2:0] bp;
    logic eerr;
    logic perr;
    logic [7:0] bank;
    logic [15:0] mode;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic irq;
    sfe_arr_cmd_t arr;
    logic arr_start;
    logic arr_abort;
    sfe_link_t link;
    logic hwr_prev;
  } sfe_ctrl_state_t;

  sfe_ctrl_state_t st;
  sfe_ctrl_state_t next_st;
  logic hw_n_s; // Reset pin after the synchroniser

  // Merge write data into a word under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // Array address from the host address, the bank and the address width
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [31:0] a, input logic [7:0] bank,
                                                 input logic addr32);
    logic [31:0] full;
    full = addr32 ? a : {bank, a[`SFE_SHORT_ADDR_W-1:0]};
    return full[ADDR_W-1:0];
  endfunction : eff_addr

  // True when an address falls in the protected range
  function automatic logic is_prot(input logic [ADDR_W-1:0] ea, input logic [2:0] bp,
                                   input logic origin);
    logic hit;
    int n;
    hit = (bp != 3'h0);
    n = 7 - int'(bp);
    for (int i = 0; i < 7; i++) begin
      if (i < n) begin
        // Top-down range compares ones, bottom-up range compares zeros
        hit = hit & (origin ? ~ea[ADDR_W-1-i] : ea[ADDR_W-1-i]);
      end
    end
    return hit;
  endfunction : is_prot

  // Clear the low bits of an address to a sector boundary
  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] ea, input int sh);
    logic [ADDR_W-1:0] m;
    m = '1;
    return ea & (m << sh);
  endfunction : align

  // Hardware reset pin comes from outside the clock domain
  sfe_sync #(
    .W(1),
    .RST(1'b1)
  ) u_hwr_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .din(hw_reset_n),
    .dout(hw_n_s)
  );

  // Next-state logic: bus slave, command checks, array handshake, interrupts
  always_comb begin
    logic wr;
    logic rd;
    logic cmd_wr;
    logic [ADDR_W-1:0] ea;
    logic [31:0] cfg_w;
    logic [31:0] stat_w;
    logic [3:0] set;
    logic [3:0] clr;
    logic uniform;
    logic [1:0] lane_f;
    wr = 1'b0;
    rd = 1'b0;
    cmd_wr = 1'b0;
    ea = '0;
    cfg_w = '0;
    stat_w = '0;
    set = 4'h0;
    clr = 4'h0;
    uniform = 1'b0;
    lane_f = 2'h0;
    next_st = st;
    if (ce) begin
      next_st.arr_start = 1'b0;
      next_st.arr_abort = 1'b0;
      next_st.hwr_prev = hw_n_s;
      uniform = st.mode[`SFE_MODE_UNIFORM];
      ea = eff_addr(st.addr, st.bank, st.mode[`SFE_MODE_ADDR32]);
      // Answer each request one cycle after it is seen, drop ack after one cycle
      wr = wb_req.cyc & wb_req.stb & wb_req.we & ~st.ack;
      rd = wb_req.cyc & wb_req.stb & ~wb_req.we & ~st.ack;
      next_st.ack = wb_req.cyc & wb_req.stb & ~st.ack;
      // Register writes
      if (wr) begin
        case (wb_req.adr)
          `SFE_OFF_CMD: begin
            cmd_wr = wb_req.sel[0];
          end
          `SFE_OFF_ADDR: begin
            next_st.addr = merge(st.addr, wb_req.dat, wb_req.sel);
          end
          `SFE_OFF_DATA: begin
            next_st.data = wb_req.sel[0] ? wb_req.dat[7:0] : st.data;
          end
          `SFE_OFF_CFG: begin
            cfg_w = merge({24'h0, st.cfg}, wb_req.dat, wb_req.sel);
            // Freeze can only be set; reset alone clears it
            next_st.cfg[`SFE_CFG_FREEZE] = st.cfg[`SFE_CFG_FREEZE] | cfg_w[`SFE_CFG_FREEZE];
            if (!st.cfg[`SFE_CFG_FREEZE]) begin
              next_st.cfg[`SFE_CFG_PARAM_LOC] = cfg_w[`SFE_CFG_PARAM_LOC];
              next_st.cfg[`SFE_CFG_PROT_ORIGIN] = cfg_w[`SFE_CFG_PROT_ORIGIN];
            end
          end
          `SFE_OFF_STAT: begin
            stat_w = merge({25'h0, st.perr, st.eerr, st.bp, 2'h0}, wb_req.dat, wb_req.sel);
            if (!st.cfg[`SFE_CFG_FREEZE]) begin
              next_st.bp = stat_w[`SFE_STAT_BP_LO +: 3];
            end
          end
          `SFE_OFF_MODE: begin
            next_st.mode = 16'(merge({16'h0, st.mode}, wb_req.dat, wb_req.sel));
          end
          `SFE_OFF_IRQ_STAT: begin
            clr = wb_req.sel[0] ? wb_req.dat[3:0] : 4'h0;
          end
          `SFE_OFF_IRQ_MASK: begin
            next_st.irq_mask = wb_req.sel[0] ? wb_req.dat[3:0] : st.irq_mask;
          end
          default: begin
            // Unmapped or read-only: acknowledged, nothing stored
          end
        endcase
      end
      // Register reads; unmapped offsets read zero
      if (rd) begin
        case (wb_req.adr)
          `SFE_OFF_ADDR: next_st.rdata = st.addr;
          `SFE_OFF_DATA: next_st.rdata = {24'h0, st.data};
          `SFE_OFF_CFG: next_st.rdata = {24'h0, st.cfg};
          `SFE_OFF_STAT: next_st.rdata = {24'h0, st.link.cont, st.perr, st.eerr, st.bp, 1'b0,
                                          st.fsm == SFE_WAIT};
          `SFE_OFF_BANK: next_st.rdata = {24'h0, st.bank};
          `SFE_OFF_MODE: next_st.rdata = {16'h0, st.mode};
          `SFE_OFF_IRQ_STAT: next_st.rdata = {28'h0, st.irq_stat};
          `SFE_OFF_IRQ_MASK: next_st.rdata = {28'h0, st.irq_mask};
          default: next_st.rdata = 32'h0;
        endcase
      end
      // Sequencer
      case (st.fsm)
        SFE_IDLE: begin
          if (cmd_wr) begin
            case (wb_req.dat[7:0])
              `SFE_OP_BANK: begin
                // Bank access only; no low-power state exists
                next_st.bank = st.data;
                set[`SFE_IRQ_DONE] = 1'b1;
              end
              `SFE_OP_PROG: begin
                if (is_prot(ea, st.bp, st.cfg[`SFE_CFG_PROT_ORIGIN])) begin
                  next_st.perr = 1'b1;
                  set[`SFE_IRQ_PERR] = 1'b1;
                end else begin
                  next_st.arr = '{kind: SFE_K_PROG, size: SFE_SZ_BYTE, addr: 32'(ea),
                                  data: st.data};
                  next_st.arr_start = 1'b1;
                  next_st.fsm = SFE_WAIT;
                end
              end
              `SFE_OP_OTP_PROG: begin
                if (st.cfg[`SFE_CFG_FREEZE]) begin
                  next_st.perr = 1'b1;
                  set[`SFE_IRQ_PERR] = 1'b1;
                end else begin
                  next_st.arr = '{kind: SFE_K_OTP, size: SFE_SZ_BYTE, addr: st.addr,
                                  data: st.data};
                  next_st.arr_start = 1'b1;
                  next_st.fsm = SFE_WAIT;
                end
              end
              `SFE_OP_ER_PAIR: begin
                set[`SFE_IRQ_REJECT] = 1'b1;
              end
              `SFE_OP_ER_SMALL: begin
                // Parameter sectors sit at the top or bottom of the array
                if (uniform || (st.cfg[`SFE_CFG_PARAM_LOC] ?
                                !(&ea[ADDR_W-1:`SFE_PARAM_SHIFT]) :
                                (|ea[ADDR_W-1:`SFE_PARAM_SHIFT]))) begin
                  set[`SFE_IRQ_REJECT] = 1'b1;
                end else if (is_prot(align(ea, `SFE_SMALL_SHIFT), st.bp,
                                     st.cfg[`SFE_CFG_PROT_ORIGIN])) begin
                  next_st.eerr = 1'b1;
                  set[`SFE_IRQ_EERR] = 1'b1;
                end else begin
                  next_st.arr = '{kind: SFE_K_ERASE, size: SFE_SZ_4K,
                                  addr: 32'(align(ea, `SFE_SMALL_SHIFT)), data: 8'hff};
                  next_st.arr_start = 1'b1;
                  next_st.fsm = SFE_WAIT;
                end
              end
              `SFE_OP_ER_BIG: begin
                // Uniform layout erases 256 KB, hybrid 64 KB
                next_st.arr.kind = SFE_K_ERASE;
                next_st.arr.data = 8'hff;
                next_st.arr.size = uniform ? SFE_SZ_256K : SFE_SZ_64K;
                next_st.arr.addr = uniform ? 32'(align(ea, `SFE_BIG_SHIFT)) :
                                   32'(align(ea, `SFE_MID_SHIFT));
                if (is_prot(uniform ? align(ea, `SFE_BIG_SHIFT) : align(ea, `SFE_MID_SHIFT),
                            st.bp, st.cfg[`SFE_CFG_PROT_ORIGIN])) begin
                  next_st.arr = st.arr;
                  next_st.eerr = 1'b1;
                  set[`SFE_IRQ_EERR] = 1'b1;
                end else begin
                  next_st.arr_start = 1'b1;
                  next_st.fsm = SFE_WAIT;
                end
              end
              `SFE_OP_READ: begin
                // Lane width for the serial engine; code 3 falls back to one lane
                lane_f = st.mode[`SFE_MODE_LANE_LO +: 2];
                next_st.link.lanes = (lane_f == 2'h1) ? SFE_LANE_TWO :
                                     (lane_f == 2'h2) ? SFE_LANE_FOUR : SFE_LANE_ONE;
                // Continuation nibble lets the next read skip the instruction
                next_st.link.cont = (st.mode[`SFE_MODE_BITS_LO + 4 +: 4] == `SFE_MODE_CONT);
                set[`SFE_IRQ_DONE] = 1'b1;
              end
              `SFE_OP_CLR: begin
                next_st.eerr = 1'b0;
                next_st.perr = 1'b0;
                set[`SFE_IRQ_DONE] = 1'b1;
              end
              default: begin
                set[`SFE_IRQ_REJECT] = 1'b1;
              end
            endcase
          end
        end
        SFE_WAIT: begin
          // Commands while busy are refused
          if (cmd_wr) begin
            set[`SFE_IRQ_REJECT] = 1'b1;
          end
          if (arr_done) begin
            next_st.fsm = SFE_IDLE;
            set[`SFE_IRQ_DONE] = 1'b1;
            if (arr_fail) begin
              // Operation counts as not completed; flag held until cleared
              if (st.arr.kind == SFE_K_ERASE) begin
                next_st.eerr = 1'b1;
                set[`SFE_IRQ_EERR] = 1'b1;
              end else begin
                next_st.perr = 1'b1;
                set[`SFE_IRQ_PERR] = 1'b1;
              end
            end
          end
        end
        default: begin
          next_st.fsm = SFE_IDLE;
        end
      endcase
      // Hardware reset pin: back to standby, bank and volatile bits cleared
      if (!hw_n_s) begin
        next_st.fsm = SFE_IDLE;
        next_st.arr_start = 1'b0;
        next_st.arr_abort = st.hwr_prev;
        next_st.bank = `SFE_BANK_RST;
        next_st.cfg = `SFE_CFG_RST;
        next_st.bp = 3'h0;
        next_st.eerr = 1'b0;
        next_st.perr = 1'b0;
        next_st.link = '{lanes: SFE_LANE_ONE, cont: 1'b0};
        set = 4'h0;
      end
      // Sticky interrupt bits: a new event wins over a clear
      next_st.irq_stat = (st.irq_stat & ~clr) | set;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '{fsm: SFE_IDLE, ack: 1'b0, rdata: 32'h0, addr: 32'h0, data: 8'h0,
              cfg: `SFE_CFG_RST, bp: 3'h0, eerr: 1'b0, perr: 1'b0, bank: `SFE_BANK_RST,
              mode: `SFE_MODE_RST, irq_stat: 4'h0, irq_mask: `SFE_MASK_RST, irq: 1'b0,
              arr: '{kind: SFE_K_PROG, size: SFE_SZ_BYTE, addr: 32'h0, data: 8'h0},
              arr_start: 1'b0, arr_abort: 1'b0,
              link: '{lanes: SFE_LANE_ONE, cont: 1'b0}, hwr_prev: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack = st.ack;
  assign wb_dat_o = st.rdata;
  assign arr_cmd = st.arr;
  assign arr_start = st.arr_start;
  assign arr_abort = st.arr_abort;
  assign link_cfg = st.link;
  assign irq = st.irq;
endmodule : sfe_ctrl

// File: sfe_ctrl_properties.sv
// Checker on the control block ports
`timescale 1ns/100ps
module sfe_ctrl_properties
  import sfe_pkg::*;
#(
  parameter int ADDR_W = 25
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire sfe_pkg::sfe_wb_req_t wb_req,
  input wire logic wb_ack,
  input wire logic hw_reset_n,
  input wire sfe_pkg::sfe_arr_cmd_t arr_cmd,
  input wire logic arr_start,
  input wire logic arr_abort,
  input wire sfe_pkg::sfe_link_t link_cfg,
  input wire logic irq
);
  logic cmd_wr; // Command write taken this edge
  assign cmd_wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack && (wb_req.adr == 8'h00);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ack; wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_src; arr_start |-> $past(cmd_wr); endproperty
  a_src: assert property (p_src) else $error("start without command");
  property p_pair; cmd_wr && wb_req.dat[7:0] == 8'h21 |=> !arr_start; endproperty
  a_pair: assert property (p_pair) else $error("pair erase started");
  property p_bank; cmd_wr && wb_req.dat[7:0] == 8'hb9 |=> !arr_start; endproperty
  a_bank: assert property (p_bank) else $error("bank code started array");
  property p_small;
    arr_start && arr_cmd.kind == SFE_K_ERASE && arr_cmd.size == SFE_SZ_4K
      |-> (arr_cmd.addr[ADDR_W-1:17] == '0) || (arr_cmd.addr[ADDR_W-1:17] == '1);
  endproperty
  a_small: assert property (p_small) else $error("small erase outside region");
  property p_abort; $fell(hw_reset_n) |-> ##[1:4] arr_abort; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_hold; (!hw_reset_n) [*4] |-> !arr_start; endproperty
  a_hold: assert property (p_hold) else $error("start in reset");
  property p_link;
    cmd_wr && wb_req.dat[7:0] != 8'h30 && hw_reset_n |=> $stable(link_cfg);
  endproperty
  a_link: assert property (p_link) else $error("link changed");
  property p_irq; irq && !(wb_req.cyc && wb_req.we) |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
endmodule : sfe_ctrl_properties
bind sfe_ctrl sfe_ctrl_properties #(.ADDR_W(ADDR_W)) sfe_ctrl_properties_inst (
  .clk_sys(clk_sys), .resetn(resetn), .wb_req(wb_req), .wb_ack(wb_ack),
  .hw_reset_n(hw_reset_n), .arr_cmd(arr_cmd), .arr_start(arr_start),
  .arr_abort(arr_abort), .link_cfg(link_cfg), .irq(irq));

// File: sfe_ctrl_tb.sv
// Self-checking bench for the flash command control block
`timescale 1ns/100ps
`include "sfe_regs.svh"
module sfe_ctrl_tb;
  import sfe_pkg::*;
  logic clk_sys = 1'b0; // System clock
  logic resetn = 1'b0; // Synchronous reset
  logic hw_reset_n = 1'b1; // Reset pin
  logic fail_req = 1'b0; // Array failure request
  sfe_wb_req_t req = '0; // Bus request
  logic wb_ack;
  logic [31:0] wb_dat_o;
  sfe_arr_cmd_t arr_cmd;
  sfe_arr_cmd_t lc; // Last started command
  logic arr_start, arr_abort, arr_done, arr_fail, irq;
  sfe_link_t link_cfg;
  int num_errors = 0;
  int total_checks = 0;
  int n_st = 0; // Starts seen
  int n_ab = 0; // Aborts seen
  int s;
  always #5 clk_sys = !clk_sys;
  sfe_ctrl #(.ADDR_W(25)) sfe_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .wb_req(req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .hw_reset_n(hw_reset_n),
    .arr_cmd(arr_cmd), .arr_start(arr_start), .arr_abort(arr_abort), .arr_done(arr_done),
    .arr_fail(arr_fail), .link_cfg(link_cfg), .irq(irq));
  sfe_array_model sfe_array_model_inst (.clk_sys(clk_sys), .resetn(resetn),
    .arr_start(arr_start), .fail_req(fail_req), .arr_done(arr_done), .arr_fail(arr_fail));
  // Count starts and aborts, keep the started command
  always @(posedge clk_sys) begin
    if (arr_start === 1'b1) begin
      n_st <= n_st + 1;
      lc <= arr_cmd;
    end
    if (arr_abort === 1'b1) n_ab <= n_ab + 1;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle, held until ack is seen
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    @(posedge clk_sys);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    // Ack and read data are taken at the rising edge that shows ack high
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      chk("wb_ack", 1, wb_ack);
      close_out();
    end else begin
      q = wb_dat_o;
      req <= '0;
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask : rd
  // Command, then wait for busy to clear
  task automatic cmd(input logic [7:0] op);
    logic [31:0] q;
    wr(`SFE_OFF_CMD, {24'h0, op});
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, `SFE_OFF_STAT, '0, q);
      if (q[0] === 1'b0) return;
    end
    chk("busy", 0, q[0]);
    close_out();
  endtask : cmd
  task automatic t_reset();
    rd(`SFE_OFF_CFG, '1, 0);
    rd(`SFE_OFF_STAT, '1, 0);
    rd(`SFE_OFF_BANK, '1, 0);
    rd(`SFE_OFF_IRQ_MASK, '1, 0);
    rd(8'h24, '1, 0);
  endtask : t_reset
  task automatic t_bank();
    wr(`SFE_OFF_DATA, 1);
    s = n_st;
    cmd(`SFE_OP_BANK);
    chk("starts", s, n_st);
    rd(`SFE_OFF_BANK, '1, 1);
    wr(`SFE_OFF_ADDR, 32'h123);
    cmd(`SFE_OP_PROG);
    chk("addr", 32'h01000123, lc.addr);
    chk("kind", 32'(SFE_K_PROG), 32'(lc.kind));
    chk("data", 1, lc.data);
    wr(`SFE_OFF_MODE, 32'h4);
    wr(`SFE_OFF_ADDR, 32'h456);
    cmd(`SFE_OP_PROG);
    chk("addr", 32'h456, lc.addr);
    wr(`SFE_OFF_MODE, 0);
  endtask : t_bank
  task automatic t_fail();
    fail_req <= 1'b1;
    cmd(`SFE_OP_ER_BIG);
    fail_req <= 1'b0;
    rd(`SFE_OFF_STAT, 32'h20, 32'h20);
    chk("size", 32'(SFE_SZ_64K), 32'(lc.size));
    wr(`SFE_OFF_MODE, 32'h8);
    cmd(`SFE_OP_ER_BIG);
    chk("size", 32'(SFE_SZ_256K), 32'(lc.size));
    rd(`SFE_OFF_STAT, 32'h20, 32'h20);
    wr(`SFE_OFF_MODE, 0);
    cmd(`SFE_OP_CLR);
    rd(`SFE_OFF_STAT, 32'h20, 0);
  endtask : t_fail
  task automatic t_small();
    s = n_st;
    cmd(`SFE_OP_ER_PAIR);
    chk("starts", s, n_st);
    rd(`SFE_OFF_IRQ_STAT, 32'h8, 32'h8);
    wr(`SFE_OFF_DATA, 0);
    cmd(`SFE_OP_BANK);
    wr(`SFE_OFF_ADDR, 32'h1f000);
    cmd(`SFE_OP_ER_SMALL);
    chk("starts", s + 1, n_st);
    chk("size", 32'(SFE_SZ_4K), 32'(lc.size));
    wr(`SFE_OFF_MODE, 32'h8);
    cmd(`SFE_OP_ER_SMALL);
    chk("starts", s + 1, n_st);
    wr(`SFE_OFF_MODE, 0);
    wr(`SFE_OFF_ADDR, 32'h20000);
    cmd(`SFE_OP_ER_SMALL);
    chk("starts", s + 1, n_st);
  endtask : t_small
  task automatic t_irq();
    wr(`SFE_OFF_IRQ_STAT, 32'hf);
    cmd(`SFE_OP_PROG);
    chk("irq", 0, irq);
    wr(`SFE_OFF_IRQ_MASK, 1);
    chk("irq", 1, irq);
    wr(`SFE_OFF_IRQ_STAT, 1);
    chk("irq", 0, irq);
    wr(`SFE_OFF_IRQ_MASK, 0);
  endtask : t_irq
  task automatic t_link();
    // Lane codes 0 to 3 with the continuation nibble, then all cleared
    for (int i = 0; i < 5; i++) begin
      wr(`SFE_OFF_MODE, (i == 4) ? 0 : (32'ha000 | i));
      cmd(`SFE_OP_READ);
      chk("link", (i == 4) ? 0 : (i == 3) ? 1 : (i * 2 + 1), 32'(link_cfg));
    end
  endtask : t_link
  task automatic t_prot();
    wr(`SFE_OFF_STAT, 32'h1c);
    s = n_st;
    cmd(`SFE_OP_PROG);
    cmd(`SFE_OP_ER_BIG);
    chk("starts", s, n_st);
    rd(`SFE_OFF_STAT, 32'h7c, 32'h7c);
    wr(`SFE_OFF_STAT, 0);
    cmd(`SFE_OP_CLR);
  endtask : t_prot
  task automatic t_freeze();
    wr(`SFE_OFF_CFG, 1);
    wr(`SFE_OFF_STAT, 32'h0c);
    rd(`SFE_OFF_STAT, 32'h1c, 0);
    wr(`SFE_OFF_CFG, 32'h25);
    rd(`SFE_OFF_CFG, '1, 1);
    s = n_st;
    cmd(`SFE_OP_OTP_PROG);
    chk("starts", s, n_st);
    rd(`SFE_OFF_STAT, 32'h40, 32'h40);
  endtask : t_freeze
  task automatic t_hwrst();
    wr(`SFE_OFF_DATA, 1);
    cmd(`SFE_OP_BANK);
    s = n_ab;
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("aborts", s + 1, n_ab);
    rd(`SFE_OFF_BANK, '1, 0);
    rd(`SFE_OFF_CFG, '1, 0);
    rd(`SFE_OFF_STAT, '1, 0);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    s = n_st;
    cmd(`SFE_OP_PROG);
    chk("starts", s + 1, n_st);
  endtask : t_hwrst
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_bank();
    t_fail();
    t_small();
    t_irq();
    t_link();
    t_prot();
    t_freeze();
    t_hwrst();
    close_out();
  end
endmodule : sfe_ctrl_tb

// File: sfe_pkg.sv
// Types shared by the flash control block, its checker and its bench
package sfe_pkg;
  // Lane count on the serial link
  typedef enum logic [1:0] {SFE_LANE_ONE, SFE_LANE_TWO, SFE_LANE_FOUR} sfe_lane_t;
  // Extent of one array operation
  typedef enum logic [1:0] {SFE_SZ_BYTE, SFE_SZ_4K, SFE_SZ_64K, SFE_SZ_256K} sfe_size_t;
  // Kind of array operation
  typedef enum logic [1:0] {SFE_K_PROG, SFE_K_OTP, SFE_K_ERASE} sfe_kind_t;
  // Request to the array
  typedef struct packed {
    sfe_kind_t kind;
    sfe_size_t size;
    logic [31:0] addr;
    logic [7:0] data;
  } sfe_arr_cmd_t;
  // Settings handed to the serial engine
  typedef struct packed {
    sfe_lane_t lanes;
    logic cont;
  } sfe_link_t;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sfe_wb_req_t;
endpackage : sfe_pkg

// File: sfe_regs.svh
// Register map, field positions, reset values and command codes of the flash control block
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH
// Byte offsets on the register bus
`define SFE_OFF_CMD 8'h00
`define SFE_OFF_ADDR 8'h04
`define SFE_OFF_DATA 8'h08
`define SFE_OFF_CFG 8'h0c
`define SFE_OFF_STAT 8'h10
`define SFE_OFF_BANK 8'h14
`define SFE_OFF_MODE 8'h18
`define SFE_OFF_IRQ_STAT 8'h1c
`define SFE_OFF_IRQ_MASK 8'h20
// Bits of config_register_first
`define SFE_CFG_FREEZE 0
`define SFE_CFG_PARAM_LOC 2
`define SFE_CFG_PROT_ORIGIN 5
// Bits of the status register
`define SFE_STAT_BUSY 0
`define SFE_STAT_BP_LO 2
`define SFE_STAT_EERR 5
`define SFE_STAT_PERR 6
`define SFE_STAT_CONT 7
// Bits of the mode register
`define SFE_MODE_LANE_LO 0
`define SFE_MODE_ADDR32 2
`define SFE_MODE_UNIFORM 3
`define SFE_MODE_BITS_LO 8
`define SFE_MODE_CONT 4'ha
// Interrupt status and mask bits
`define SFE_IRQ_DONE 0
`define SFE_IRQ_PERR 1
`define SFE_IRQ_EERR 2
`define SFE_IRQ_REJECT 3
// Command codes written to the command register
`define SFE_OP_BANK 8'hb9
`define SFE_OP_PROG 8'h10
`define SFE_OP_OTP_PROG 8'h11
`define SFE_OP_ER_SMALL 8'h20
`define SFE_OP_ER_PAIR 8'h21
`define SFE_OP_ER_BIG 8'h22
`define SFE_OP_READ 8'h30
`define SFE_OP_CLR 8'h40
// Sector geometry as address bit positions
`define SFE_SMALL_SHIFT 12
`define SFE_MID_SHIFT 16
`define SFE_BIG_SHIFT 18
`define SFE_PARAM_SHIFT 17
`define SFE_SHORT_ADDR_W 24
// Reset values
`define SFE_CFG_RST 8'h00
`define SFE_MODE_RST 16'h0000
`define SFE_MASK_RST 4'h0
`define SFE_BANK_RST 8'h00
`endif

// File: sfe_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module sfe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // Both stages as one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfe_sync_state_t;

  sfe_sync_state_t st;
  sfe_sync_state_t next_st;

  // Shift the pin through two stages
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = din;
      next_st.s2 = st.s1;
    end
  end

  // Register the stages
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '{s1: RST, s2: RST};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule : sfe_sync
